// ### verilog/abm_exec.sv
// abm_exec: executes move-effective-address, block word copy and two-operand multiply
//
// What this block does
// - opcode 0x04 stores source effective address into destination
// - illegal operand on bad effective-address source/destination modes
// - address move: N=msb, Z=zero, C=V=0
// - 0x3019 copy uses r0 src, r1 dst, r2 count
// - copy word, step addresses 4, count 1; flags kept
// - interrupts accepted only between copy iterations
// - registers update only after faultable access completes
// - multiply dst by src, size from opcode
// - multiply: N negative, Z zero, C=0, V overflow
// - multiply: overflow exception on truncation, illegal dst
//
// Local design decisions: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module abm_exec
   import abm_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic mem_req,
   output logic mem_we,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   input wire logic [31:0] mem_rdata,
   input wire logic mem_ack,
   input wire logic mem_fault,
   input wire logic int_pending,
   output logic int_accept,
   output logic int_hold
);
   ////////////////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed {
      logic wait_r;
      logic [31:0] rdata;
      logic [15:0] opcode;
      logic [7:0] modes;
      logic [31:0] src_ea;
      logic [31:0] src_val;
      logic [31:0] dst_val;
      logic [31:0] r0;
      logic [31:0] r1;
      logic [31:0] r2;
      logic [3:0] nzcv;
      logic exc_illegal;
      logic exc_overflow;
      logic mem_fault;
      logic interrupted;
      logic bad_opcode;
      abm_blk_t blk;
      logic req;
      logic we;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic int_acc;
      logic hold;
   } abm_exec_state_t;

   abm_exec_state_t s_r;
   abm_exec_state_t s_nxt;

   localparam abm_exec_state_t STATE_RESET = '{
      wait_r: 1'b1,
      rdata: WORD_ZERO,
      opcode: OPCODE_RESET,
      modes: MODES_RESET,
      src_ea: WORD_ZERO,
      src_val: WORD_ZERO,
      dst_val: WORD_ZERO,
      r0: WORD_ZERO,
      r1: WORD_ZERO,
      r2: WORD_ZERO,
      nzcv: FLAGS_RESET,
      exc_illegal: 1'b0,
      exc_overflow: 1'b0,
      mem_fault: 1'b0,
      interrupted: 1'b0,
      bad_opcode: 1'b0,
      blk: ABM_BLK_IDLE,
      req: 1'b0,
      we: 1'b0,
      addr: WORD_ZERO,
      wdata: WORD_ZERO,
      int_acc: 1'b0,
      hold: 1'b0
   };

   ////////////////////////////////////////////////////////////////////////////////
   // submodules and decode helpers
   logic buf_in_valid;
   logic buf_in_ready;
   logic buf_out_valid;
   logic buf_out_ready;
   logic [31:0] buf_out_data;
   logic buf_flush;
   logic [31:0] mul_product;
   logic mul_overflow;
   abm_size_t mul_size;
   abm_mode_t src_mode;
   abm_mode_t dst_mode;
   logic src_ea_bad;
   logic dst_bad;
   logic busy;
   logic accept;
   logic [31:0] status_word;

   // staging buffer between copy reads and copy writes
   abm_word_buffer u_buf (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .ce(ce),
      .flush(buf_flush),
      .in_valid(buf_in_valid),
      .in_ready(buf_in_ready),
      .in_data(mem_rdata),
      .out_valid(buf_out_valid),
      .out_ready(buf_out_ready),
      .out_data(buf_out_data)
   );

   // sized signed multiply
   abm_multiplier u_mul (
      .dst_in(s_r.dst_val),
      .src_in(s_r.src_val),
      .size(mul_size),
      .product(mul_product),
      .overflow(mul_overflow)
   );

   // operand size from the opcode
   always_comb begin
      unique case (s_r.opcode)
         OPC_MUL_BYTE: mul_size = ABM_SIZE_BYTE;
         OPC_MUL_HALF: mul_size = ABM_SIZE_HALF;
         default: mul_size = ABM_SIZE_WORD;
      endcase
   end

   // addressing mode checks
   assign src_mode = abm_mode_t'(s_r.modes[MODE_SRC_LSB +: 3]);
   assign dst_mode = abm_mode_t'(s_r.modes[MODE_DST_LSB +: 3]);
   assign src_ea_bad = (src_mode == ABM_MODE_LITERAL) || (src_mode == ABM_MODE_REGISTER)
      || (src_mode == ABM_MODE_IMMEDIATE);
   assign dst_bad = (dst_mode == ABM_MODE_LITERAL) || (dst_mode == ABM_MODE_IMMEDIATE);

   // requests taken once wait is low
   assign busy = (s_r.blk != ABM_BLK_IDLE);
   assign accept = (avs_read || avs_write) && !s_r.wait_r;

   // status word
   always_comb begin
      status_word = WORD_ZERO;
      status_word[3:0] = s_r.nzcv;
      status_word[ST_BUSY] = busy;
      status_word[ST_ILLEGAL] = s_r.exc_illegal;
      status_word[ST_OVERFLOW] = s_r.exc_overflow;
      status_word[ST_MEM_FAULT] = s_r.mem_fault;
      status_word[ST_INTERRUPTED] = s_r.interrupted;
      status_word[ST_BAD_OPCODE] = s_r.bad_opcode;
   end

   // buffer handshakes: push on read ack, pop on write ack
   assign buf_in_valid = (s_r.blk == ABM_BLK_READ) && s_r.req && mem_ack && !mem_fault;
   assign buf_out_ready = (s_r.blk == ABM_BLK_WRITE) && s_r.req && mem_ack && !mem_fault;
   // fault drops the staged word
   assign buf_flush = busy && s_r.req && mem_fault;

   ////////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      s_nxt = s_r;
      s_nxt.int_acc = 1'b0;
      // bus slave: one wait cycle, read data staged in it
      s_nxt.wait_r = !((avs_read || avs_write) && s_r.wait_r);
      if (avs_read && s_r.wait_r) begin
         unique case (avs_address)
            OFS_OPCODE: s_nxt.rdata = {16'h0000, s_r.opcode};
            OFS_MODES: s_nxt.rdata = {24'h000000, s_r.modes};
            OFS_SRC_EA: s_nxt.rdata = s_r.src_ea;
            OFS_SRC_VAL: s_nxt.rdata = s_r.src_val;
            OFS_DST_VAL: s_nxt.rdata = s_r.dst_val;
            OFS_R0: s_nxt.rdata = s_r.r0;
            OFS_R1: s_nxt.rdata = s_r.r1;
            OFS_R2: s_nxt.rdata = s_r.r2;
            OFS_STATUS: s_nxt.rdata = status_word;
            default: s_nxt.rdata = WORD_ZERO;
         endcase
      end

      // register writes; operands are locked while a copy runs
      // refused writes still complete
      if (accept && avs_write && !busy) begin
         unique case (avs_address)
            OFS_MODES: s_nxt.modes = avs_writedata[7:0];
            OFS_SRC_EA: s_nxt.src_ea = avs_writedata;
            OFS_SRC_VAL: s_nxt.src_val = avs_writedata;
            OFS_DST_VAL: s_nxt.dst_val = avs_writedata;
            OFS_R0: s_nxt.r0 = avs_writedata;
            OFS_R1: s_nxt.r1 = avs_writedata;
            OFS_R2: s_nxt.r2 = avs_writedata;
            OFS_STATUS: s_nxt.nzcv = avs_writedata[3:0];
            OFS_OPCODE: begin
               s_nxt.opcode = avs_writedata[15:0];
               // new instruction clears the previous outcome
               s_nxt.exc_illegal = 1'b0;
               s_nxt.exc_overflow = 1'b0;
               s_nxt.mem_fault = 1'b0;
               s_nxt.interrupted = 1'b0;
               s_nxt.bad_opcode = 1'b0;
               unique case (avs_writedata[15:0])
                  OPC_MOVE_EA: begin
                     if (src_ea_bad || dst_bad) begin
                        s_nxt.exc_illegal = 1'b1;
                     end else begin
                        s_nxt.dst_val = s_r.src_ea;
                        s_nxt.nzcv = {s_r.src_ea[31], s_r.src_ea == WORD_ZERO, 2'b00};
                     end
                  end
                  OPC_BLOCK_COPY: begin
                     // a zero count finishes at once with nothing moved
                     if (s_r.r2 != WORD_ZERO) begin
                        s_nxt.blk = ABM_BLK_READ;
                        s_nxt.hold = 1'b1;
                     end
                  end
                  OPC_MUL_BYTE, OPC_MUL_HALF, OPC_MUL_WORD: begin
                     // multiply result is formed on the next cycle
                     if (dst_bad) begin
                        s_nxt.exc_illegal = 1'b1;
                        s_nxt.opcode = OPCODE_RESET;
                     end
                  end
                  default: s_nxt.bad_opcode = 1'b1;
               endcase
            end
            default: begin
            end
         endcase
      end

      // multiply completes one cycle after the opcode write
      if (s_r.opcode inside {OPC_MUL_BYTE, OPC_MUL_HALF, OPC_MUL_WORD}) begin
         s_nxt.dst_val = mul_product;
         s_nxt.nzcv = {mul_product[31], mul_product == WORD_ZERO, 1'b0, mul_overflow};
         s_nxt.exc_overflow = mul_overflow;
         s_nxt.opcode = OPCODE_RESET;
      end

      // block copy sequencer; flags are never touched here
      unique case (s_r.blk)
         ABM_BLK_IDLE: begin
            s_nxt.hold = s_nxt.hold && (s_nxt.blk != ABM_BLK_IDLE);
         end
         ABM_BLK_READ: begin
            if (!s_r.req && buf_in_ready) begin
               s_nxt.req = 1'b1;
               s_nxt.we = 1'b0;
               s_nxt.addr = s_r.r0;
            end else if (s_r.req && mem_fault) begin
               // abort before any register moved
               s_nxt.req = 1'b0;
               s_nxt.mem_fault = 1'b1;
               s_nxt.blk = ABM_BLK_IDLE;
               s_nxt.hold = 1'b0;
            end else if (s_r.req && mem_ack) begin
               s_nxt.req = 1'b0;
               s_nxt.blk = ABM_BLK_WRITE;
            end
         end
         ABM_BLK_WRITE: begin
            if (!s_r.req && buf_out_valid) begin
               s_nxt.req = 1'b1;
               s_nxt.we = 1'b1;
               s_nxt.addr = s_r.r1;
               s_nxt.wdata = buf_out_data;
            end else if (s_r.req && mem_fault) begin
               s_nxt.req = 1'b0;
               s_nxt.we = 1'b0;
               s_nxt.mem_fault = 1'b1;
               s_nxt.blk = ABM_BLK_IDLE;
               s_nxt.hold = 1'b0;
            end else if (s_r.req && mem_ack) begin
               // iteration done: only now step the registers
               s_nxt.req = 1'b0;
               s_nxt.we = 1'b0;
               s_nxt.r0 = s_r.r0 + ADDR_STEP;
               s_nxt.r1 = s_r.r1 + ADDR_STEP;
               s_nxt.r2 = s_r.r2 - COUNT_STEP;
               if (s_r.r2 == COUNT_STEP) begin
                  s_nxt.blk = ABM_BLK_IDLE;
                  s_nxt.hold = 1'b0;
               end else if (int_pending) begin
                  // iteration boundary: let the pending interrupt in
                  s_nxt.blk = ABM_BLK_IDLE;
                  s_nxt.hold = 1'b0;
                  s_nxt.int_acc = 1'b1;
                  s_nxt.interrupted = 1'b1;
               end else begin
                  s_nxt.blk = ABM_BLK_READ;
               end
            end
         end
         default: begin
            s_nxt.blk = ABM_BLK_IDLE;
            s_nxt.req = 1'b0;
            s_nxt.hold = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state register, frozen while ce is low
   // reset acts even with ce low
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s_r <= STATE_RESET;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   // outputs straight from flip-flops
   assign avs_readdata = s_r.rdata;
   assign avs_waitrequest = s_r.wait_r;
   assign mem_req = s_r.req;
   assign mem_we = s_r.we;
   assign mem_addr = s_r.addr;
   assign mem_wdata = s_r.wdata;
   assign int_accept = s_r.int_acc;
   assign int_hold = s_r.hold;
endmodule
`default_nettype wire

// ### verilog/abm_pkg.sv
// abm_pkg: constants, register map and types for the address, block copy and multiply unit
package abm_pkg;
   // opcodes
   localparam logic [15:0] OPC_MOVE_EA = 16'h0004;
   localparam logic [15:0] OPC_BLOCK_COPY = 16'h3019;
   localparam logic [15:0] OPC_MUL_BYTE = 16'h00AB;
   localparam logic [15:0] OPC_MUL_HALF = 16'h00AA;
   localparam logic [15:0] OPC_MUL_WORD = 16'h00A8;
   // register byte offsets
   localparam logic [5:0] OFS_OPCODE = 6'h00;
   localparam logic [5:0] OFS_MODES = 6'h04;
   localparam logic [5:0] OFS_SRC_EA = 6'h08;
   localparam logic [5:0] OFS_SRC_VAL = 6'h0C;
   localparam logic [5:0] OFS_DST_VAL = 6'h10;
   localparam logic [5:0] OFS_R0 = 6'h14;
   localparam logic [5:0] OFS_R1 = 6'h18;
   localparam logic [5:0] OFS_R2 = 6'h1C;
   localparam logic [5:0] OFS_STATUS = 6'h20;
   // field positions
   localparam int MODE_SRC_LSB = 0;
   localparam int MODE_DST_LSB = 4;
   localparam int ST_BUSY = 8;
   localparam int ST_ILLEGAL = 9;
   localparam int ST_OVERFLOW = 10;
   localparam int ST_MEM_FAULT = 11;
   localparam int ST_INTERRUPTED = 12;
   localparam int ST_BAD_OPCODE = 13;
   // reset values and steps
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   localparam logic [31:0] ADDR_STEP = 32'h0000_0004;
   localparam logic [31:0] COUNT_STEP = 32'h0000_0001;
   localparam logic [3:0] FLAGS_RESET = 4'h0;
   localparam logic [15:0] OPCODE_RESET = 16'h0000;
   localparam logic [7:0] MODES_RESET = 8'h00;
   // operand addressing modes, three bits
   typedef enum logic [2:0] {
      ABM_MODE_MEMORY = 3'b000,
      ABM_MODE_LITERAL = 3'b001,
      ABM_MODE_REGISTER = 3'b010,
      ABM_MODE_IMMEDIATE = 3'b011,
      ABM_MODE_DISP = 3'b100,
      ABM_MODE_DEFER = 3'b101,
      ABM_MODE_ABS = 3'b110,
      ABM_MODE_EXPANDED = 3'b111
   } abm_mode_t;
   // multiply operand size
   typedef enum logic [1:0] {
      ABM_SIZE_BYTE = 2'b00,
      ABM_SIZE_HALF = 2'b01,
      ABM_SIZE_WORD = 2'b10
   } abm_size_t;
   // block copy sequencer
   typedef enum logic [1:0] {
      ABM_BLK_IDLE = 2'b00,
      ABM_BLK_READ = 2'b01,
      ABM_BLK_WRITE = 2'b10
   } abm_blk_t;
endpackage

// ### verilog/abm_word_buffer.sv
// abm_word_buffer: two-entry word buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module abm_word_buffer
   import abm_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [31:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [31:0] out_data
);
   typedef struct packed {
      logic [1:0][31:0] mem;
      logic wr_idx;
      logic rd_idx;
      logic [1:0] fill;
   } abm_buf_state_t;

   abm_buf_state_t s_r;
   abm_buf_state_t s_nxt;

   // honest full and empty from the fill count
   assign in_ready = (s_r.fill != 2'h2);
   assign out_valid = (s_r.fill != 2'h0);
   assign out_data = s_r.mem[s_r.rd_idx];

   // push, pop and flush
   always_comb begin
      s_nxt = s_r;
      if (in_valid && in_ready) begin
         s_nxt.mem[s_r.wr_idx] = in_data;
         s_nxt.wr_idx = ~s_r.wr_idx;
      end
      if (out_valid && out_ready) begin
         s_nxt.rd_idx = ~s_r.rd_idx;
      end
      s_nxt.fill = s_r.fill + {1'b0, in_valid && in_ready} - {1'b0, out_valid && out_ready};
      if (flush) begin
         s_nxt.wr_idx = 1'b0;
         s_nxt.rd_idx = 1'b0;
         s_nxt.fill = 2'h0;
      end
   end

   // state register
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s_r <= '0;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end
endmodule
`default_nettype wire

// ### verilog/abm_multiplier.sv
// abm_multiplier: signed multiply in byte, halfword or word size with overflow detect
`timescale 1ns/1ps
`default_nettype none
module abm_multiplier
   import abm_pkg::*;
(
   input wire logic [31:0] dst_in,
   input wire logic [31:0] src_in,
   input wire abm_size_t size,
   output logic [31:0] product,
   output logic overflow
);
   logic [31:0] a_ext;
   logic [31:0] b_ext;
   logic signed [63:0] full;

   // sign-extend operands, multiply, truncate and compare
   always_comb begin
      a_ext = dst_in;
      b_ext = src_in;
      product = WORD_ZERO;
      unique case (size)
         ABM_SIZE_BYTE: begin
            a_ext = {{24{dst_in[7]}}, dst_in[7:0]};
            b_ext = {{24{src_in[7]}}, src_in[7:0]};
         end
         ABM_SIZE_HALF: begin
            a_ext = {{16{dst_in[15]}}, dst_in[15:0]};
            b_ext = {{16{src_in[15]}}, src_in[15:0]};
         end
         ABM_SIZE_WORD: begin
            a_ext = dst_in;
            b_ext = src_in;
         end
         default: begin
            a_ext = dst_in;
            b_ext = src_in;
         end
      endcase
      full = $signed(a_ext) * $signed(b_ext);
      unique case (size)
         ABM_SIZE_BYTE: product = {{24{full[7]}}, full[7:0]};
         ABM_SIZE_HALF: product = {{16{full[15]}}, full[15:0]};
         default: product = full[31:0];
      endcase
      // truncation shows as a difference from the exact product
      overflow = ($signed({{32{product[31]}}, product}) != full);
   end
endmodule
`default_nettype wire

// ### verif/abm_exec_monitor.sv
// abm_exec_monitor: port-level checks on the execution unit
`timescale 1ns/1ps
`default_nettype none
module abm_exec_monitor
   import abm_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   input wire logic mem_ack,
   input wire logic mem_fault,
   input wire logic int_pending,
   input wire logic int_accept,
   input wire logic int_hold
);
   ////////////////////////////////////////////////////////////////////////////////
   // one clock domain; reset or a frozen clock enable mutes every check
   default clocking cb_mon @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n || !ce);
   // read answered, then the write of that word after one idle cycle
   sequence s_read_done; mem_req && !mem_we && mem_ack && !mem_fault; endsequence
   sequence s_write_issue; !mem_req ##1 (mem_req && mem_we); endsequence
   ////////////////////////////////////////////////////////////////////////////////
   // register bus handshake
   wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus request not answered");
   wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   // memory master of the block copy
   mem_hold_a: assert property (mem_req && !mem_ack && !mem_fault |=> mem_req && $stable(mem_addr)
      && $stable(mem_we) && $stable(mem_wdata)) else $error("memory request not held");
   mem_drop_a: assert property (mem_req && (mem_ack || mem_fault) |=> !mem_req)
      else $error("memory request not released");
   read_write_a: assert property (s_read_done |=> s_write_issue)
      else $error("copied word not written back");
   fault_stop_a: assert property (mem_req && mem_fault |=> !mem_req [*3])
      else $error("copy went on after a fault");
   // interrupts only between iterations
   copy_hold_a: assert property (mem_req |-> int_hold)
      else $error("memory access with interrupts open");
   accept_gate_a: assert property (int_accept |-> !int_hold && !mem_req && $past(int_pending))
      else $error("interrupt accepted inside an iteration");
   accept_pulse_a: assert property (int_accept |=> !int_accept)
      else $error("interrupt accept longer than one cycle");
endmodule
////////////////////////////////////////////////////////////////////////////////
// attach to every instance of the unit
bind abm_exec abm_exec_monitor i_mon (.*);
`default_nettype wire

// ### verif/abm_mem_model.sv
// abm_mem_model: word memory behind the copy engine, with stalls and fault injection
`timescale 1ns/1ps
`default_nettype none
module abm_mem_model
   import abm_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   output logic [31:0] mem_rdata,
   output logic mem_ack,
   output logic mem_fault,
   input wire logic slow,
   input wire logic fault_en,
   input wire logic [31:0] fault_addr
);
   logic [31:0] mem_r [0:255];
   logic [1:0] wait_r;
   wire logic live = mem_req && !mem_ack && !mem_fault;
   ////////////////////////////////////////////////////////////////////////////////
   // answer after a random stall; read data is only good in the answer cycle
   always @(posedge clk_sys) begin
      mem_ack <= 1'b0;
      mem_fault <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_r <= slow ? 2'($urandom_range(3)) : 2'h0;
      if (!rst_n) begin
         mem_rdata <= 32'h0;
      end else if (live && wait_r != 2'h0) begin
         wait_r <= wait_r - 2'h1;
      end else if (live && fault_en && mem_addr == fault_addr) begin
         mem_fault <= 1'b1;
      end else if (live) begin
         mem_ack <= 1'b1;
         if (mem_we) mem_r[mem_addr[9:2]] <= mem_wdata;
         else mem_rdata <= mem_r[mem_addr[9:2]];
      end
   end
endmodule
`default_nettype wire

// ### verif/tb_addr_blockmove_multiply_exec.sv
// tb_addr_blockmove_multiply_exec: random and corner tests of the execution unit
`timescale 1ns/1ps
`default_nettype none
module tb_addr_blockmove_multiply_exec import abm_pkg::*;;
   logic clk_sys = 1'b0, rst_n = 1'b0, ce = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
   logic int_pending = 1'b0, slow = 1'b0, fault_en = 1'b0;
   logic [5:0] avs_address = 6'h00;
   logic [31:0] avs_writedata = 32'h0, fault_addr = 32'h0;
   logic [31:0] avs_readdata, mem_addr, mem_wdata, mem_rdata, rd, v, d, s, st;
   logic avs_waitrequest, mem_req, mem_we, mem_ack, mem_fault, int_accept, int_hold;
   logic [7:0] md;
   logic [32:0] m;
   logic [31:0] exp_w [0:15];
   logic [15:0] mop [0:2] = '{OPC_MUL_BYTE, OPC_MUL_HALF, OPC_MUL_WORD};
   int num_errors = 0, compares = 0, i;
   ////////////////////////////////////////////////////////////////////////////////
   // 50 MHz clock, unit and the memory behind it
   always #10 clk_sys = ~clk_sys;
   abm_exec i_dut (.*);
   abm_mem_model i_mem (.*);
   ////////////////////////////////////////////////////////////////////////////////
   // compare and count
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   // print counts and verdict, then end the run
   task automatic report_and_stop();
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // one bus transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd);
      int c;
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= !wr;
      for (c = 0; c < 20; c++) begin
         @(posedge clk_sys);
         if (avs_waitrequest === 1'b0) break;
      end
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (c == 20) begin
         num_errors++;
         report_and_stop();
      end
   endtask
   // read a register and compare
   task automatic rchk(input string what, input logic [5:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(what, rd, exp);
   endtask
   // load operands, preset flags from st and issue one instruction
   task automatic op(input logic [15:0] opc, input logic [7:0] mds, input logic [31:0] ea, dv, sv);
      bus(1'b1, OFS_MODES, {24'h0, mds});
      bus(1'b1, OFS_SRC_EA, ea);
      bus(1'b1, OFS_SRC_VAL, sv);
      bus(1'b1, OFS_DST_VAL, dv);
      bus(1'b1, OFS_STATUS, {28'h0, st[3:0]});
      bus(1'b1, OFS_OPCODE, {16'h0, opc});
   endtask
   // expected signed product, truncated and sign-extended, with the truncation flag on top
   function automatic logic [32:0] mul_exp(input int sz, input logic [31:0] a, input logic [31:0] b);
      logic signed [63:0] p;
      logic [31:0] r;
      p = (sz == 0) ? $signed(a[7:0]) * $signed(b[7:0]) :
         (sz == 1) ? $signed(a[15:0]) * $signed(b[15:0]) : $signed(a) * $signed(b);
      r = (sz == 0) ? {{24{p[7]}}, p[7:0]} : (sz == 1) ? {{16{p[15]}}, p[15:0]} : p[31:0];
      return {$signed(r) != p, r};
   endfunction
   // issue a copy, try a write while busy when n is nonzero, wait for busy to clear
   task automatic go(input logic [31:0] n);
      int w;
      bus(1'b1, OFS_STATUS, {28'h0, st[3:0]});
      bus(1'b1, OFS_OPCODE, {16'h0, OPC_BLOCK_COPY});
      if (n != 32'h0) bus(1'b1, OFS_R0, 32'hFFFF_FFF0);
      for (w = 0; w < 300; w++) begin
         bus(1'b0, OFS_STATUS, 32'h0);
         if (rd[ST_BUSY] === 1'b0) break;
      end
      if (w == 300) begin
         num_errors++;
         report_and_stop();
      end
   endtask
   // check the three copy registers and the status word
   task automatic regs(input logic [31:0] a0, a1, n, sx);
      rchk("src addr", OFS_R0, a0);
      rchk("dst addr", OFS_R1, a1);
      rchk("count", OFS_R2, n);
      rchk("copy status", OFS_STATUS, sx | {28'h0, st[3:0]});
   endtask
   // copy that stops after done words, then resumes to the end
   task automatic blk(input logic [31:0] a0, a1, n, done, sx);
      st = $urandom;
      bus(1'b1, OFS_R0, a0);
      bus(1'b1, OFS_R1, a1);
      bus(1'b1, OFS_R2, n);
      go(n);
      regs(a0 + 4 * done, a1 + 4 * done, n - done, sx);
      fault_en <= 1'b0;
      int_pending <= 1'b0;
      go(n - done);
      regs(a0 + 4 * n, a1 + 4 * n, 32'h0, 32'h0);
      for (int k = 0; k < n; k++) begin
         check("copied word", i_mem.mem_r[(a1 >> 2) + k], exp_w[(a0 >> 2) - 64 + k]);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      v = $urandom(32'h8B08);
      repeat (5) @(posedge clk_sys);
      check("idle wait", {31'h0, avs_waitrequest}, 32'h1);
      check("idle copy", {30'h0, mem_req, int_hold}, 32'h0);
      rst_n <= 1'b1;
      bus(1'b1, 6'h3C, 32'h1234_5678);
      rchk("unmapped", 6'h3C, 32'h0);
      rchk("count reset", OFS_R2, 32'h0);
      // legal address moves, zero and negative first
      for (i = 0; i < 10; i++) begin
         v = (i == 0) ? 32'h0 : (i == 1) ? 32'h8000_0000 : $urandom;
         st = $urandom;
         md = {1'b0, i[0] ? 3'h2 : 3'h0, 1'b0, (i > 0 && i < 5) ? 3'(i + 3) : 3'h0};
         op(OPC_MOVE_EA, md, v, $urandom, $urandom);
         rchk("ea result", OFS_DST_VAL, v);
         rchk("ea flags", OFS_STATUS, {28'h0, v[31], v == 32'h0, 2'b00});
      end
      // every forbidden operand mode
      for (i = 0; i < 5; i++) begin
         st = $urandom;
         d = $urandom;
         md = (i < 3) ? 8'(i + 1) : (i == 3) ? 8'h10 : 8'h30;
         op(OPC_MOVE_EA, md, $urandom, d, 32'h0);
         rchk("ea kept", OFS_DST_VAL, d);
         rchk("ea illegal", OFS_STATUS, {22'h0, 1'b1, 5'h0, st[3:0]});
         if (i > 2) begin
            op(OPC_MUL_HALF, md, 32'h0, d, 32'h3);
            rchk("mul kept", OFS_DST_VAL, d);
            rchk("mul illegal", OFS_STATUS, {22'h0, 1'b1, 5'h0, st[3:0]});
         end
      end
      // multiplies in all three sizes: zero, overflow corners, random, small
      for (i = 0; i < 24; i++) begin
         d = (i < 3) ? 32'h0 : (i < 6) ? 32'h8000_8080 : (i < 15) ? $urandom : $urandom_range(20) - 10;
         s = (i < 6) ? 32'h8000_8080 : (i < 15) ? $urandom : $urandom_range(20) - 10;
         st = $urandom;
         op(mop[i % 3], 8'h01, 32'h0, d, s);
         m = mul_exp(i % 3, d, s);
         rchk("product", OFS_DST_VAL, m[31:0]);
         rchk("mul status", OFS_STATUS, {21'h0, m[32], 6'h0, m[31], m[31:0] == 32'h0, 1'b0, m[32]});
      end
      op(16'h00FF, 8'h00, 32'h0, d, d);
      rchk("bad opcode", OFS_STATUS, {18'h0, 1'b1, 9'h0, st[3:0]});
      // block copies with a stalling memory
      slow <= 1'b1;
      for (i = 0; i < 16; i++) begin
         exp_w[i] = $urandom;
         i_mem.mem_r[64 + i] = exp_w[i];
      end
      blk(32'h100, 32'h200, 32'h0, 32'h0, 32'h0);
      blk(32'h100, 32'h200, 32'h5, 32'h5, 32'h0);
      fault_en <= 1'b1;
      fault_addr <= 32'h11C;
      blk(32'h114, 32'h214, 32'h4, 32'h2, 32'h800);
      fault_en <= 1'b1;
      fault_addr <= 32'h228;
      blk(32'h124, 32'h224, 32'h4, 32'h1, 32'h800);
      int_pending <= 1'b1;
      blk(32'h134, 32'h234, 32'h3, 32'h1, 32'h1000);
      report_and_stop();
   end
endmodule
`default_nettype wire
